// >>> core/rtc_power_control.sv
// rtc-domain power-down control with axi4-lite register access
`timescale 1ns/1ps
`default_nettype none
module rtc_power_control
#(
   parameter int ADDR_W = 16,
   parameter int unsigned REFERENCE_RECOVERY_CYCLES =
      int'(power_down_pkg::REFERENCE_RECOVERY_CYCLES)
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rouse_pin_in,
   output logic rouse_pin_out,
   output logic rouse_pin_oe,
   input wire logic rtc_alarm,
   output logic rtc_clock_output_enable,
   output logic reference_on,
   output logic analog_regulator_on,
   output logic analog_por_on,
   output logic usb_core_regulator_on,
   output logic regulators_ready,
   output logic irq
);

   // ***************************************************
   // decode helpers
   // ***************************************************

   // word-aligned address match against a byte offset
   function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                input logic [15:0] offset);
      hit = (addr[ADDR_W-1:2] == offset[ADDR_W-1:2]);
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] addr);
      mapped = hit(addr, power_down_pkg::RTC_POWER_MANAGEMENT_OFFSET) ||
               hit(addr, power_down_pkg::USB_REGULATOR_CONTROL_OFFSET) ||
               hit(addr, power_down_pkg::EVENT_STATUS_OFFSET) ||
               hit(addr, power_down_pkg::EVENT_MASK_OFFSET);
   endfunction

   // ***************************************************
   // state
   // ***************************************************
   logic [4:0] pm;
   logic usb_regulator_enable;
   logic [1:0] event_status;
   logic [1:0] event_mask;
   power_down_pkg::power_state_t state;
   power_down_pkg::power_state_t next_state;
   logic full_shutdown;
   logic aw_held;
   logic [ADDR_W-1:0] aw_addr;
   logic w_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [4:0] next_pm;
   logic next_usb_enable;
   logic [1:0] next_status;
   logic [1:0] next_mask;
   logic next_full_shutdown;
   logic [31:0] timer_remaining;
   logic timer_expired;

   // ***************************************************
   // axi4-lite handshakes
   // ***************************************************
   wire write_fire = aw_held && w_held && !s_axi_bvalid;
   wire wr_low = write_fire && w_strb[0];
   wire wr_pm = wr_low &&
      hit(aw_addr, power_down_pkg::RTC_POWER_MANAGEMENT_OFFSET);
   wire wr_usb = wr_low &&
      hit(aw_addr, power_down_pkg::USB_REGULATOR_CONTROL_OFFSET);
   wire wr_status = wr_low &&
      hit(aw_addr, power_down_pkg::EVENT_STATUS_OFFSET);
   wire wr_mask = wr_low &&
      hit(aw_addr, power_down_pkg::EVENT_MASK_OFFSET);
   wire read_fire = s_axi_arvalid && s_axi_arready;

   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign s_axi_arready = !s_axi_rvalid;

   // address and data are held separately, taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
      else if (write_fire)
         aw_held <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
      else if (write_fire)
         w_held <= 1'b0;
   end

   // write response, error for an unmapped word
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= power_down_pkg::RESP_OKAY;
      end
      else if (write_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= mapped(aw_addr) ? power_down_pkg::RESP_OKAY :
                        power_down_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // read words, reserved bits always zero
   wire [31:0] pm_word = {27'h0, pm};
   wire [31:0] usb_word = {31'h0, usb_regulator_enable};
   wire [31:0] status_word = {30'h0, event_status};
   wire [31:0] mask_word = {30'h0, event_mask};
   wire [31:0] read_word =
      hit(s_axi_araddr, power_down_pkg::RTC_POWER_MANAGEMENT_OFFSET) ?
         pm_word :
      hit(s_axi_araddr, power_down_pkg::USB_REGULATOR_CONTROL_OFFSET) ?
         usb_word :
      hit(s_axi_araddr, power_down_pkg::EVENT_STATUS_OFFSET) ?
         status_word :
      hit(s_axi_araddr, power_down_pkg::EVENT_MASK_OFFSET) ?
         mask_word : 32'h0;

   // read answer one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= power_down_pkg::RESP_OKAY;
      end
      else if (read_fire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= read_word;
         s_axi_rresp <= mapped(s_axi_araddr) ? power_down_pkg::RESP_OKAY :
                        power_down_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ***************************************************
   // wake qualification and sequencing
   // ***************************************************

   // pin counts only as an input; alarm always counts
   wire pin_wake = !pm[power_down_pkg::ROUSE_DIR_BIT] &&
                   rouse_pin_in;
   wire wake_event = (state == power_down_pkg::ST_SHUTDOWN) &&
                     (pin_wake || rtc_alarm);
   wire shutdown_req = pm[power_down_pkg::REFERENCE_SHUTDOWN_BIT] ||
                       pm[power_down_pkg::REGULATOR_SHUTDOWN_BIT];
   wire recovery_done = (state == power_down_pkg::ST_RECOVER) &&
                        timer_expired && !shutdown_req;
   wire [31:0] recovery_load = full_shutdown ?
      32'(REFERENCE_RECOVERY_CYCLES) :
      32'(power_down_pkg::REGULATOR_SETTLE_CYCLES);

   // state transitions; shutdown only ends on a wake event
   always_comb
   begin
      next_state = state;
      case (state)
         power_down_pkg::ST_RUN:
            if (shutdown_req)
               next_state = power_down_pkg::ST_SHUTDOWN;
         power_down_pkg::ST_SHUTDOWN:
            if (wake_event)
               next_state = power_down_pkg::ST_RECOVER;
         power_down_pkg::ST_RECOVER:
            if (shutdown_req)
               next_state = power_down_pkg::ST_SHUTDOWN;
            else if (timer_expired)
               next_state = power_down_pkg::ST_RUN;
         default:
            next_state = power_down_pkg::ST_RUN;
      endcase
   end

   // kind of shutdown caught on entry, full one dominates
   assign next_full_shutdown =
      (next_state == power_down_pkg::ST_SHUTDOWN &&
       state != power_down_pkg::ST_SHUTDOWN) ?
         pm[power_down_pkg::REFERENCE_SHUTDOWN_BIT] : full_shutdown;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= power_down_pkg::ST_RUN;
         full_shutdown <= 1'b0;
      end
      else
      begin
         state <= next_state;
         full_shutdown <= next_full_shutdown;
      end
   end

   recovery_timer #(
      .CW(32)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(wake_event),
      .load_value(recovery_load),
      .remaining(timer_remaining),
      .expired(timer_expired)
   );

   // ***************************************************
   // register updates
   // ***************************************************

   // wake clears the shutdown bits; a software write in that cycle wins
   always_comb
   begin
      next_pm = pm;
      if (wake_event)
      begin
         next_pm[power_down_pkg::REFERENCE_SHUTDOWN_BIT] = 1'b0;
         next_pm[power_down_pkg::REGULATOR_SHUTDOWN_BIT] = 1'b0;
      end
      if (wr_pm)
         next_pm = w_data[4:0];
   end

   assign next_usb_enable = wr_usb ? w_data[0] : usb_regulator_enable;

   // sticky events: set wins over a write-one clear
   assign next_status =
      (wr_status ? (event_status & ~w_data[1:0]) : event_status) |
      {recovery_done, wake_event};
   assign next_mask = wr_mask ? w_data[1:0] : event_mask;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pm <= power_down_pkg::PM_RESET;
         usb_regulator_enable <= power_down_pkg::USB_ENABLE_RESET;
         event_status <= power_down_pkg::EVENT_RESET;
         event_mask <= power_down_pkg::EVENT_RESET;
      end
      else
      begin
         pm <= next_pm;
         usb_regulator_enable <= next_usb_enable;
         event_status <= next_status;
         event_mask <= next_mask;
      end
   end

   assign irq = |(event_status & event_mask);

   // ***************************************************
   // supply and pin outputs
   // ***************************************************
   wire next_off = (next_state == power_down_pkg::ST_SHUTDOWN);

   // registered enables follow the state entered at this edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         reference_on <= 1'b1;
         analog_regulator_on <= 1'b1;
         analog_por_on <= 1'b1;
         usb_core_regulator_on <= 1'b0;
         regulators_ready <= 1'b1;
         rtc_clock_output_enable <= 1'b0;
         rouse_pin_oe <= 1'b0;
      end
      else
      begin
         reference_on <= !(next_off && next_full_shutdown);
         analog_regulator_on <= !next_off;
         analog_por_on <= !next_off;
         usb_core_regulator_on <= !next_off && next_usb_enable;
         regulators_ready <= (next_state == power_down_pkg::ST_RUN);
         rtc_clock_output_enable <=
            next_pm[power_down_pkg::CLOCK_OUT_BIT];
         rouse_pin_oe <= next_pm[power_down_pkg::ROUSE_DIR_BIT] &&
            !next_pm[power_down_pkg::ROUSE_OUT_BIT];
      end
   end

   // open drain: only ever pulls low
   assign rouse_pin_out = 1'b0;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_wake;
      wake_event;
   endsequence

   sequence s_powered;
      state == power_down_pkg::ST_RECOVER && analog_regulator_on;
   endsequence

   property p_pm_write;
      wr_pm |=> pm_word[31:5] == 27'h0 && pm == $past(w_data[4:0]);
   endproperty
   a_pm_write: assert property (p_pm_write)
      else $error("power-management write not stored as five bits");

   property p_rouse_drive;
      ##1 rouse_pin_oe == ($past(next_pm[3]) && !$past(next_pm[4])) &&
          !rouse_pin_out;
   endproperty
   a_rouse_drive: assert property (p_rouse_drive)
      else $error("rouse pin drive does not follow direction and value");

   property p_no_pin_wake_as_output;
      (state == power_down_pkg::ST_SHUTDOWN && pm[3] && !rtc_alarm)
         |=> state == power_down_pkg::ST_SHUTDOWN;
   endproperty
   a_no_pin_wake_as_output: assert property (p_no_pin_wake_as_output)
      else $error("pin woke the block while configured as output");

   property p_full_off;
      (state == power_down_pkg::ST_SHUTDOWN && full_shutdown) |->
         !reference_on && !analog_regulator_on && !analog_por_on &&
         !usb_core_regulator_on;
   endproperty
   a_full_off: assert property (p_full_off)
      else $error("full shutdown left a circuit running");

   property p_regulator_off;
      (state == power_down_pkg::ST_SHUTDOWN && !full_shutdown) |->
         reference_on && !analog_regulator_on && !analog_por_on;
   endproperty
   a_regulator_off: assert property (p_regulator_off)
      else $error("regulator shutdown handled the reference wrongly");

   property p_wake_restores;
      s_wake |=> s_powered;
   endproperty
   a_wake_restores: assert property (p_wake_restores)
      else $error("wake event did not restore the regulators");

   property p_recovery_time;
      (wake_event && full_shutdown) |=>
         timer_remaining == REFERENCE_RECOVERY_CYCLES;
   endproperty
   a_recovery_time: assert property (p_recovery_time)
      else $error("reference recovery wait not loaded");

   property p_clock_out;
      wr_pm |=> rtc_clock_output_enable == $past(w_data[0]);
   endproperty
   a_clock_out: assert property (p_clock_out)
      else $error("clock output enable does not follow bit zero");

   property p_usb_follow;
      (state == power_down_pkg::ST_RUN) |->
         usb_core_regulator_on == usb_regulator_enable &&
         (!usb_core_regulator_on || analog_regulator_on);
   endproperty
   a_usb_follow: assert property (p_usb_follow)
      else $error("usb regulator does not follow its enable");

   property p_reset_values;
      $past(!aresetn) |-> pm == power_down_pkg::PM_RESET &&
         !usb_regulator_enable;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("wrong field values after reset");

   property p_shutdown_holds;
      (state == power_down_pkg::ST_SHUTDOWN && !wake_event) |=>
         state == power_down_pkg::ST_SHUTDOWN && !analog_regulator_on;
   endproperty
   a_shutdown_holds: assert property (p_shutdown_holds)
      else $error("shutdown ended without a wake event");

endmodule
`default_nettype wire

// >>> core/power_down_pkg.sv
// constants and types shared by the rtc power-down control block
`default_nettype none
package power_down_pkg;

   // ***************************************************
   // register byte offsets
   // ***************************************************
   localparam logic [15:0] RTC_POWER_MANAGEMENT_OFFSET = 16'h1930;
   localparam logic [15:0] USB_REGULATOR_CONTROL_OFFSET = 16'h7004;
   localparam logic [15:0] EVENT_STATUS_OFFSET = 16'h7008;
   localparam logic [15:0] EVENT_MASK_OFFSET = 16'h700c;

   // ***************************************************
   // field positions and reset values
   // ***************************************************
   localparam int PM_WIDTH = 5;
   localparam int CLOCK_OUT_BIT = 0;
   localparam int REGULATOR_SHUTDOWN_BIT = 1;
   localparam int REFERENCE_SHUTDOWN_BIT = 2;
   localparam int ROUSE_DIR_BIT = 3;
   localparam int ROUSE_OUT_BIT = 4;
   localparam logic [4:0] PM_RESET = 5'h10;
   localparam logic USB_ENABLE_RESET = 1'b0;
   localparam int EVENT_WIDTH = 2;
   localparam int WAKE_TAKEN_BIT = 0;
   localparam int RECOVERY_DONE_BIT = 1;
   localparam logic [1:0] EVENT_RESET = 2'h0;

   // ***************************************************
   // bus answers
   // ***************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ***************************************************
   // timing: reference recovery after a full shutdown, regulator settling after a regulator shutdown
   // ***************************************************
   localparam longint unsigned CLOCK_HZ = 64'd40000000;
   localparam longint unsigned REFERENCE_RECOVERY_MS = 64'd100;
   localparam longint unsigned REFERENCE_RECOVERY_CYCLES =
      (REFERENCE_RECOVERY_MS * CLOCK_HZ) / 64'd1000;
   localparam int unsigned REGULATOR_SETTLE_CYCLES = 1;

   // ***************************************************
   // sequencer states, gray coded along run-shutdown-recover
   // ***************************************************
   typedef enum logic [1:0]
   {
      ST_RUN = 2'b00,
      ST_SHUTDOWN = 2'b01,
      ST_RECOVER = 2'b11
   } power_state_t;

endpackage
`default_nettype wire

// >>> core/recovery_timer.sv
// down-counter that times the regulator and reference recovery
`timescale 1ns/1ps
`default_nettype none
module recovery_timer
#(
   parameter int CW = 32
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire logic [CW-1:0] load_value,
   output logic [CW-1:0] remaining,
   output logic expired
);

   // load wins; otherwise count down to zero and stay
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         remaining <= '0;
      else if (load)
         remaining <= load_value;
      else if (remaining != '0)
         remaining <= remaining - 1'b1;
   end

   assign expired = (remaining == '0);

endmodule
`default_nettype wire

// >>> verification/rouse_source.sv
// wake pin source with its pull-up resistor, facing the power control block
`timescale 1ns/1ps
`default_nettype none
module rouse_source
(
   input wire logic pin_oe,
   input wire logic pin_out,
   input wire logic drive_en,
   input wire logic drive_level,
   output logic pin_level
);
   // open-drain low wins, then the outside driver, else the pull-up
   assign pin_level = pin_oe ? pin_out :
                      (drive_en ? drive_level : 1'b1);
endmodule
`default_nettype wire

// >>> verification/test_regulator_power_down_control.sv
// self-checking bench for the rtc power-down control block
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         num_errors++; \
         $display("unexpected %s: expected %h seen %h", what, exp, got); \
      end \
   end
module test_regulator_power_down_control;
   localparam int RECOVERY = 20;
   localparam int SETTLE = int'(power_down_pkg::REGULATOR_SETTLE_CYCLES);
   localparam logic [15:0] PM = power_down_pkg::RTC_POWER_MANAGEMENT_OFFSET;
   localparam logic [15:0] USB = power_down_pkg::USB_REGULATOR_CONTROL_OFFSET;
   localparam logic [15:0] STAT = power_down_pkg::EVENT_STATUS_OFFSET;
   localparam logic [15:0] MASK = power_down_pkg::EVENT_MASK_OFFSET;
   localparam logic [1:0] OK = power_down_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = power_down_pkg::RESP_SLVERR;
   logic aclk = 1'b0;
   logic aresetn, awvalid, wvalid, bready, arvalid, rready, alarm;
   logic awready, wready, bvalid, arready, rvalid;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd, wd;
   logic [1:0] bresp, rresp, resp;
   logic pin, pin_out, pin_oe, drv_en, drv_lvl, clk_out;
   logic ref_on, ana_on, por_on, usb_on, ready, irq;
   logic [15:0] adr [4] = '{PM, USB, STAT, MASK};
   logic [31:0] rst_val [4] = '{32'h10, 32'h0, 32'h0, 32'h0};
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;
   integer seed = 32'heef84e7d;

   always #12.5 aclk = ~aclk;

   rtc_power_control #(.REFERENCE_RECOVERY_CYCLES(RECOVERY)) dut
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .rouse_pin_in(pin), .rouse_pin_out(pin_out),
      .rouse_pin_oe(pin_oe), .rtc_alarm(alarm),
      .rtc_clock_output_enable(clk_out), .reference_on(ref_on),
      .analog_regulator_on(ana_on), .analog_por_on(por_on),
      .usb_core_regulator_on(usb_on), .regulators_ready(ready), .irq(irq)
   );

   rouse_source partner
   (
      .pin_oe(pin_oe), .pin_out(pin_out), .drive_en(drv_en),
      .drive_level(drv_lvl), .pin_level(pin)
   );

   // ***************************************************
   // expectations and bus tasks
   // ***************************************************
   function automatic logic [31:0] pm_read(input logic [31:0] d);
      return d & 32'h0000001f;
   endfunction

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && dd))
      begin
         @(posedge aclk);
         if (awvalid && awready)
         begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready)
         begin
            dd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd_word(input logic [15:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic wait_ready();
      n = 0;
      while (ready !== 1'b1 && n < 200)
      begin
         @(negedge aclk);
         n++;
      end
   endtask

   task automatic summarize();
      $display("checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // cut a hung run short
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         summarize();
      end
   end

   // ***************************************************
   // main sequence
   // ***************************************************
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, alarm} = '0;
      {awaddr, araddr, wdata} = '0;
      drv_en = 1'b1;
      drv_lvl = 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      `CHECK("ready", 1'b1, ready);
      `CHECK("oe", 1'b0, pin_oe);
      for (int i = 0; i < 4; i++)
      begin
         rd_word(adr[i]);
         `CHECK("reset value", rst_val[i], rd);
      end
      rd_word(16'h0100);
      `CHECK("unmapped read", ERR, resp);
      wr(16'h0100, 32'h1);
      `CHECK("unmapped write", ERR, resp);
      drv_en <= 1'b0;
      // random fields with both shutdown bits clear
      for (int i = 0; i < 16; i++)
      begin
         wd = $random(seed) & 32'hfffffff9;
         wr(PM, wd);
         `CHECK("pm write resp", OK, resp);
         rd_word(PM);
         `CHECK("pm read resp", OK, resp);
         `CHECK("pm readback", pm_read(wd), rd);
         @(negedge aclk);
         `CHECK("clock out", wd[0], clk_out);
         `CHECK("oe", wd[3] & ~wd[4], pin_oe);
         `CHECK("pin level", ~(wd[3] & ~wd[4]), pin);
         wd = $random(seed);
         wr(USB, wd);
         rd_word(USB);
         `CHECK("usb readback", wd & 32'h1, rd);
         @(negedge aclk);
         `CHECK("usb on", wd[0], usb_on);
         `CHECK("analog on", 1'b1, ana_on);
      end
      // regulators are never bypassed here, so shutdown is allowed
      wr(USB, 32'h1);
      wr(PM, 32'h1a);
      repeat (12) @(negedge aclk);
      `CHECK("reference kept", 1'b1, ref_on);
      `CHECK("analog off", 1'b0, ana_on);
      `CHECK("por off", 1'b0, por_on);
      `CHECK("usb forced off", 1'b0, usb_on);
      wr(PM, 32'h18);
      repeat (3) @(negedge aclk);
      `CHECK("still off", 1'b0, ana_on);
      @(posedge aclk);
      alarm <= 1'b1;
      @(posedge aclk);
      alarm <= 1'b0;
      @(negedge aclk);
      `CHECK("alarm wake", 1'b1, ana_on);
      `CHECK("usb follows", 1'b1, usb_on);
      wait_ready();
      `CHECK("short recovery", SETTLE + 1, n);
      // sticky events, mask and level interrupt
      rd_word(STAT);
      `CHECK("status", 32'h3, rd);
      `CHECK("irq masked", 1'b0, irq);
      wr(MASK, 32'h1);
      @(negedge aclk);
      `CHECK("irq", 1'b1, irq);
      wr(STAT, 32'h1);
      rd_word(STAT);
      `CHECK("w1c", 32'h2, rd);
      `CHECK("irq cleared", 1'b0, irq);
      wr(MASK, 32'h3);
      @(negedge aclk);
      `CHECK("irq", 1'b1, irq);
      wr(STAT, 32'h2);
      @(negedge aclk);
      `CHECK("irq cleared", 1'b0, irq);
      // full shutdown, woken by the pin as an input
      drv_en <= 1'b1;
      wr(PM, 32'h14);
      repeat (3) @(negedge aclk);
      `CHECK("reference off", 1'b0, ref_on);
      `CHECK("analog off", 1'b0, ana_on);
      `CHECK("por off", 1'b0, por_on);
      @(posedge aclk);
      drv_lvl <= 1'b1;
      @(posedge aclk);
      drv_lvl <= 1'b0;
      @(negedge aclk);
      `CHECK("pin wake", 1'b1, ref_on);
      wait_ready();
      `CHECK("long recovery", RECOVERY + 1, n);
      rd_word(PM);
      `CHECK("shutdown released", 32'h10, rd);
      summarize();
   end
endmodule
`default_nettype wire
